// ===== rtl/otc_pkg.sv
// Register map, field layout and constants of the oscillator trim control block
`default_nettype none
package otc_pkg;
   localparam logic [7:0]  OTC_OFF_TRIM_CTL   = 8'h00;
   localparam logic [7:0]  OTC_OFF_REF_CFG    = 8'h04;
   localparam logic [7:0]  OTC_OFF_STATUS     = 8'h08;
   localparam logic [7:0]  OTC_OFF_FLAG_CLR   = 8'h0c;
   localparam logic [31:0] OTC_TRIM_CTL_RST   = 32'h0000_2000;
   localparam logic [31:0] OTC_REF_CFG_RST    = 32'h2022_bb7f;
   localparam logic [31:0] OTC_REF_CFG_MASK   = 32'hb7ff_ffff;
   localparam int          OTC_TRIM_LSB       = 8;
   localparam int          OTC_TRIM_W         = 6;
   localparam int          OTC_SOFT_PULSE_BIT = 7;
   localparam int          OTC_HW_TRIM_BIT    = 6;
   localparam int          OTC_CNT_EN_BIT     = 5;
   localparam int          OTC_IRQ_W          = 4;
   localparam int          OTC_IRQ_OK         = 0;
   localparam int          OTC_IRQ_WARN       = 1;
   localparam int          OTC_IRQ_ERR        = 2;
   localparam int          OTC_IRQ_EREF       = 3;
   localparam int          OTC_POL_BIT        = 31;
   localparam int          OTC_SEL_LSB        = 28;
   localparam int          OTC_SEL_W          = 2;
   localparam int          OTC_PSC_LSB        = 24;
   localparam int          OTC_PSC_W          = 3;
   localparam int          OTC_LIM_LSB        = 16;
   localparam int          OTC_LIM_W          = 8;
   localparam int          OTC_RELOAD_W       = 16;
   localparam int          OTC_CAP_LSB        = 16;
   localparam int          OTC_DIR_BIT        = 15;
   localparam int          OTC_RANGE_ERR_BIT  = 10;
   localparam int          OTC_MISS_BIT       = 9;
   localparam int          OTC_SLOW_BIT       = 8;
   localparam logic [1:0]  OTC_SRC_GPIO       = 2'h0;
   localparam logic [1:0]  OTC_SRC_LOW_SPEED_CRYSTAL      = 2'h1;
   localparam logic [1:0]  OTC_SRC_SOF        = 2'h2;
   localparam logic [5:0]  OTC_TRIM_MAX       = 6'h3f;
   localparam logic [5:0]  OTC_TRIM_MIN       = 6'h00;
   localparam int          OTC_TRIM_STEP_KHZ  = 57;
   localparam int          OTC_UP_SHIFT       = 7;
   localparam int          OTC_SYNC_STAGES    = 3;
   localparam int          OTC_SRC_N          = 3;

   typedef enum logic [1:0] {
      OTC_CNT_IDLE = 2'b00,
      OTC_CNT_DOWN = 2'b01,
      OTC_CNT_UP   = 2'b10,
      OTC_CNT_HALT = 2'b11
   } otc_cnt_mode_t;
endpackage : otc_pkg
`default_nettype wire

// ===== rtl/otc_ref_sync.sv
// Reference input synchronisers, edge selection and prescaler
`default_nettype none
module otc_ref_sync
   import otc_pkg::*;
#(
   parameter int PSC_W = OTC_PSC_W
) (
   input  wire logic                 mclk_i,
   input  wire logic                 sys_rst_i,
   input  wire logic [OTC_SRC_N-1:0] ref_raw_i,
   input  wire logic                 cnt_en_i,
   input  wire logic                 pol_i,
   input  wire logic [1:0]           sel_i,
   input  wire logic [PSC_W-1:0]     psc_i,
   output logic                      pulse_o
);
   localparam int DIV_W = (1 << PSC_W) - 1;

   typedef struct packed {
      logic [OTC_SRC_N-1:0] s1;
      logic [OTC_SRC_N-1:0] s2;
      logic [OTC_SRC_N-1:0] s3;
      logic [OTC_SRC_N-1:0] lvl;
      logic                 prev;
      logic [DIV_W-1:0]     div;
      logic                 pulse;
   } otc_rs_state_t;

   otc_rs_state_t st_q;
   otc_rs_state_t st_d;
   logic          cur;
   logic          edge_hit;
   logic [DIV_W:0]   span;
   logic [DIV_W-1:0] div_top;

   always_comb begin
      st_d = st_q;
      st_d.s1 = ref_raw_i;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      // Level moves only once two late stages agree
      st_d.lvl = ((st_q.s2 ~^ st_q.s3) & st_q.s2) | ((st_q.s2 ^ st_q.s3) & st_q.lvl);
      cur = (sel_i == OTC_SRC_GPIO)  ? st_q.lvl[0] :
            (sel_i == OTC_SRC_LOW_SPEED_CRYSTAL) ? st_q.lvl[1] :
            (sel_i == OTC_SRC_SOF)   ? st_q.lvl[2] : 1'b0;
      st_d.prev = cur;
      edge_hit = pol_i ? (st_q.prev & ~cur) : (~st_q.prev & cur);
      // divide by two to the code
      span = (DIV_W + 1)'(1) << psc_i;
      div_top = DIV_W'(span - (DIV_W + 1)'(1));
      st_d.pulse = 1'b0;
      if (!cnt_en_i) begin
         st_d.div = '0;
      end else if (edge_hit) begin
         if (st_q.div == div_top) begin
            st_d.div = '0;
            st_d.pulse = 1'b1;
         end else begin
            st_d.div = st_q.div + DIV_W'(1);
         end
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pulse_o = st_q.pulse;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   pulse_single_a: assert property (pulse_o |=> !pulse_o)
      else $error("prescaler pulse lasted two cycles");
   pulse_gated_a: assert property (!cnt_en_i |=> !pulse_o)
      else $error("prescaler pulse while counter disabled");
endmodule : otc_ref_sync
`default_nettype wire

// ===== rtl/otc_trim_cnt.sv
// Trim counter with reload, down and up phases and frequency evaluation
`default_nettype none
module otc_trim_cnt
   import otc_pkg::*;
#(
   parameter int CNT_W = OTC_RELOAD_W,
   parameter int LIM_W = OTC_LIM_W
) (
   input  wire logic             mclk_i,
   input  wire logic             sys_rst_i,
   input  wire logic             cnt_en_i,
   input  wire logic             sync_i,
   input  wire logic [CNT_W-1:0] reload_i,
   input  wire logic [LIM_W-1:0] limit_i,
   output logic                  eval_o,
   output logic                  ok_o,
   output logic                  warn_o,
   output logic                  slow_o,
   output logic [1:0]            step_o,
   output logic                  raise_o,
   output logic                  miss_o,
   output logic                  zero_o,
   output logic [CNT_W-1:0]      cap_o
);
   typedef struct packed {
      otc_cnt_mode_t    mode;
      logic [CNT_W-1:0] cnt;
      logic             eval;
      logic             ok;
      logic             warn;
      logic             slow;
      logic [1:0]       step;
      logic             raise;
      logic             miss;
      logic             zero;
      logic [CNT_W-1:0] cap;
   } otc_tc_state_t;

   otc_tc_state_t    st_q;
   otc_tc_state_t    st_d;
   logic [CNT_W-1:0] lim1;
   logic [CNT_W-1:0] lim3;
   logic [CNT_W-1:0] lim_top;
   logic             down;

   always_comb begin
      lim1 = CNT_W'(limit_i);
      lim3 = CNT_W'(lim1 + {lim1[CNT_W-2:0], 1'b0});
      lim_top = CNT_W'({limit_i, OTC_UP_SHIFT'(0)});
      down = (st_q.mode == OTC_CNT_DOWN);
      st_d = st_q;
      st_d.eval = 1'b0;
      st_d.ok = 1'b0;
      st_d.warn = 1'b0;
      st_d.slow = 1'b0;
      st_d.step = 2'h0;
      st_d.miss = 1'b0;
      st_d.zero = 1'b0;
      st_d.raise = down;
      if (!cnt_en_i) begin
         st_d.mode = OTC_CNT_IDLE;
      end else if (sync_i) begin
         st_d.cnt = reload_i;
         st_d.mode = OTC_CNT_DOWN;
         st_d.cap = st_q.cnt;
         if (st_q.mode == OTC_CNT_DOWN || st_q.mode == OTC_CNT_UP) begin
            st_d.eval = 1'b1;
            if (down && st_q.cnt >= lim_top) begin
               st_d.slow = 1'b1;
            end else if (st_q.cnt < lim1) begin
               st_d.ok = 1'b1;
            end else if (st_q.cnt < lim3) begin
               st_d.ok = 1'b1;
               st_d.step = 2'h1;
            end else begin
               st_d.warn = 1'b1;
               st_d.step = 2'h2;
            end
         end
      end else begin
         // down to zero, up to 128x limit, halt
         case (st_q.mode)
            OTC_CNT_DOWN: begin
               if (st_q.cnt == '0) begin
                  st_d.mode = OTC_CNT_UP;
                  st_d.zero = 1'b1;
               end else begin
                  st_d.cnt = st_q.cnt - CNT_W'(1);
               end
            end
            OTC_CNT_UP: begin
               if (st_q.cnt == lim_top) begin
                  st_d.mode = OTC_CNT_HALT;
                  st_d.miss = 1'b1;
               end else begin
                  st_d.cnt = st_q.cnt + CNT_W'(1);
               end
            end
            default: begin
               st_d.mode = st_q.mode;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign eval_o  = st_q.eval;
   assign ok_o    = st_q.ok;
   assign warn_o  = st_q.warn;
   assign slow_o  = st_q.slow;
   assign step_o  = st_q.step;
   assign raise_o = st_q.raise;
   assign miss_o  = st_q.miss;
   assign zero_o  = st_q.zero;
   assign cap_o   = st_q.cap;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   reload_on_sync_a: assert property (cnt_en_i && sync_i |=> st_q.cnt == $past(reload_i)
      && st_q.mode == OTC_CNT_DOWN)
      else $error("counter not reloaded on sync");
   zero_turns_up_a: assert property (zero_o |-> st_q.mode == OTC_CNT_UP || $past(sync_i)
      || !$past(cnt_en_i))
      else $error("counter did not turn up at zero");
endmodule : otc_trim_cnt
`default_nettype wire

// ===== rtl/otc_top.sv
// Oscillator trim control block: APB registers, trim adjustment and flags
`default_nettype none
module otc_top
   import otc_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   input  wire logic        ref_gpio_i,
   input  wire logic        ref_low_speed_crystal_i,
   input  wire logic        ref_sof_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             irq_o,
   output logic      [5:0]  trim_code_o
);
   typedef struct packed {
      logic [OTC_TRIM_W-1:0]   trim_code;
      logic                    hw_trim_enable;
      logic                    trim_counter_enable;
      logic [OTC_IRQ_W-1:0]    irq_enable;
      logic                    soft_sync_pulse;
      logic [31:0]             ref_config;
      logic [OTC_IRQ_W-1:0]    flags;
      logic                    trim_range_error;
      logic                    ref_pulse_missing;
      logic                    trim_too_slow_error;
      logic [OTC_RELOAD_W-1:0] cap;
      logic                    cap_dir;
      logic [31:0]             prdata;
      logic                    pready;
      logic                    pslverr;
      logic                    irq;
   } otc_top_state_t;

   // reset code is the midpoint, about 57KHz per step
   localparam otc_top_state_t ST_RST = '{
      trim_code:  OTC_TRIM_CTL_RST[OTC_TRIM_LSB +: OTC_TRIM_W],
      ref_config: OTC_REF_CFG_RST,
      default:    '0
   };

   function automatic logic otc_hit(input logic [7:0] addr, input logic [7:0] off);
      otc_hit = (addr[7:2] == off[7:2]);
   endfunction : otc_hit

   otc_top_state_t          st_q;
   otc_top_state_t          st_d;
   logic                    setup;
   logic                    wr_acc;
   logic                    mapped;
   logic [31:0]             rd_word;
   logic                    ref_pulse;
   logic                    cnt_sync;
   logic                    ev_eval;
   logic                    ev_ok;
   logic                    ev_warn;
   logic                    ev_slow;
   logic [1:0]              ev_step;
   logic                    ev_raise;
   logic                    ev_miss;
   logic                    ev_zero;
   logic [OTC_RELOAD_W-1:0] ev_cap;
   logic [7:0]              trim_up;
   logic [7:0]              trim_dn;

   assign setup  = psel_i & ~penable_i;
   assign wr_acc = psel_i & penable_i & st_q.pready & pwrite_i;
   assign mapped = otc_hit(paddr_i, OTC_OFF_TRIM_CTL) | otc_hit(paddr_i, OTC_OFF_REF_CFG)
                 | otc_hit(paddr_i, OTC_OFF_STATUS) | otc_hit(paddr_i, OTC_OFF_FLAG_CLR);
   // soft pulse joins the prescaled reference
   assign cnt_sync = st_q.soft_sync_pulse | ref_pulse;

   otc_ref_sync #(
      .PSC_W(OTC_PSC_W)
   ) u_ref_sync (
      .mclk_i   (mclk_i),
      .sys_rst_i(sys_rst_i),
      .ref_raw_i({ref_sof_i, ref_low_speed_crystal_i, ref_gpio_i}),
      .cnt_en_i (st_q.trim_counter_enable),
      .pol_i    (st_q.ref_config[OTC_POL_BIT]),
      .sel_i    (st_q.ref_config[OTC_SEL_LSB +: OTC_SEL_W]),
      .psc_i    (st_q.ref_config[OTC_PSC_LSB +: OTC_PSC_W]),
      .pulse_o  (ref_pulse)
   );

   otc_trim_cnt #(
      .CNT_W(OTC_RELOAD_W),
      .LIM_W(OTC_LIM_W)
   ) u_trim_cnt (
      .mclk_i   (mclk_i),
      .sys_rst_i(sys_rst_i),
      .cnt_en_i (st_q.trim_counter_enable),
      .sync_i   (cnt_sync),
      .reload_i (st_q.ref_config[OTC_RELOAD_W-1:0]),
      .limit_i  (st_q.ref_config[OTC_LIM_LSB +: OTC_LIM_W]),
      .eval_o   (ev_eval),
      .ok_o     (ev_ok),
      .warn_o   (ev_warn),
      .slow_o   (ev_slow),
      .step_o   (ev_step),
      .raise_o  (ev_raise),
      .miss_o   (ev_miss),
      .zero_o   (ev_zero),
      .cap_o    (ev_cap)
   );

   always_comb begin
      rd_word = '0;
      if (otc_hit(paddr_i, OTC_OFF_TRIM_CTL)) begin
         rd_word[OTC_TRIM_LSB +: OTC_TRIM_W] = st_q.trim_code;
         rd_word[OTC_HW_TRIM_BIT] = st_q.hw_trim_enable;
         rd_word[OTC_CNT_EN_BIT] = st_q.trim_counter_enable;
         rd_word[OTC_IRQ_W-1:0] = st_q.irq_enable;
      end else if (otc_hit(paddr_i, OTC_OFF_REF_CFG)) begin
         rd_word = st_q.ref_config;
      end else if (otc_hit(paddr_i, OTC_OFF_STATUS)) begin
         rd_word[OTC_CAP_LSB +: OTC_RELOAD_W] = st_q.cap;
         rd_word[OTC_DIR_BIT] = st_q.cap_dir;
         rd_word[OTC_RANGE_ERR_BIT] = st_q.trim_range_error;
         rd_word[OTC_MISS_BIT] = st_q.ref_pulse_missing;
         rd_word[OTC_SLOW_BIT] = st_q.trim_too_slow_error;
         rd_word[OTC_IRQ_W-1:0] = st_q.flags;
      end
   end

   always_comb begin
      trim_up = {2'h0, st_q.trim_code} + {6'h00, ev_step};
      trim_dn = {2'h0, st_q.trim_code} - {6'h00, ev_step};
      st_d = st_q;
      st_d.soft_sync_pulse = 1'b0;
      st_d.pready = setup;
      st_d.pslverr = setup & ~mapped;
      if (setup) begin
         st_d.prdata = rd_word;
      end
      if (wr_acc && otc_hit(paddr_i, OTC_OFF_TRIM_CTL)) begin
         if (pstrb_i[0]) begin
            st_d.soft_sync_pulse = pwdata_i[OTC_SOFT_PULSE_BIT];
            st_d.hw_trim_enable = pwdata_i[OTC_HW_TRIM_BIT];
            st_d.trim_counter_enable = pwdata_i[OTC_CNT_EN_BIT];
            st_d.irq_enable = pwdata_i[OTC_IRQ_W-1:0];
         end
         // manual trim write, blocks it in auto mode
         if (pstrb_i[1] && !st_q.hw_trim_enable) begin
            st_d.trim_code = pwdata_i[OTC_TRIM_LSB +: OTC_TRIM_W];
         end
      end
      // locked while counting; whole words only
      if (wr_acc && otc_hit(paddr_i, OTC_OFF_REF_CFG) && !st_q.trim_counter_enable
          && pstrb_i == 4'hf) begin
         st_d.ref_config = pwdata_i & OTC_REF_CFG_MASK;
      end
      if (wr_acc && otc_hit(paddr_i, OTC_OFF_FLAG_CLR) && pstrb_i[0]) begin
         st_d.flags = st_q.flags & ~pwdata_i[OTC_IRQ_W-1:0];
         if (pwdata_i[OTC_IRQ_ERR]) begin
            st_d.trim_range_error = 1'b0;
            st_d.ref_pulse_missing = 1'b0;
            st_d.trim_too_slow_error = 1'b0;
         end
      end
      // Hardware sets follow the clears so a same-cycle event survives
      if (ev_eval) begin
         st_d.cap = ev_cap;
         st_d.cap_dir = ev_raise;
         if (ev_ok) begin
            st_d.flags[OTC_IRQ_OK] = 1'b1;
         end
         if (ev_warn) begin
            st_d.flags[OTC_IRQ_WARN] = 1'b1;
         end
         if (ev_slow) begin
            st_d.trim_too_slow_error = 1'b1;
            st_d.flags[OTC_IRQ_ERR] = 1'b1;
         end
         // adjust toward target; raise when slow, lower when fast
         if (st_q.hw_trim_enable && ev_step != 2'h0) begin
            if (ev_raise && trim_up[OTC_TRIM_W]) begin
               st_d.trim_code = OTC_TRIM_MAX;
               st_d.trim_range_error = 1'b1;
               st_d.flags[OTC_IRQ_ERR] = 1'b1;
            end else if (!ev_raise && trim_dn[7]) begin
               st_d.trim_code = OTC_TRIM_MIN;
               st_d.trim_range_error = 1'b1;
               st_d.flags[OTC_IRQ_ERR] = 1'b1;
            end else begin
               st_d.trim_code = ev_raise ? trim_up[OTC_TRIM_W-1:0] : trim_dn[OTC_TRIM_W-1:0];
            end
         end
      end
      if (ev_miss) begin
         st_d.ref_pulse_missing = 1'b1;
         st_d.flags[OTC_IRQ_ERR] = 1'b1;
      end
      if (ev_zero) begin
         st_d.flags[OTC_IRQ_EREF] = 1'b1;
      end
      st_d.irq = |(st_d.flags & st_d.irq_enable);
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata_o    = st_q.prdata;
   assign pready_o    = st_q.pready;
   assign pslverr_o   = st_q.pslverr;
   assign irq_o       = st_q.irq;
   assign trim_code_o = st_q.trim_code;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   sequence setup_s;
      psel_i && !penable_i;
   endsequence

   sequence trim_wr_s;
      wr_acc && otc_hit(paddr_i, OTC_OFF_TRIM_CTL);
   endsequence

   sequence auto_step_s(logic up, logic [1:0] n);
      ev_eval && st_q.hw_trim_enable && ev_raise == up && ev_step == n;
   endsequence

   apb_ready_a: assert property (setup_s |=> pready_o ##1 !pready_o)
      else $error("pready not one cycle after setup");

   manual_trim_a: assert property (trim_wr_s ##0 (pstrb_i[1] && !st_q.hw_trim_enable)
      |=> trim_code_o == $past(pwdata_i[OTC_TRIM_LSB +: OTC_TRIM_W]))
      else $error("manual trim write lost");

   auto_hold_a: assert property (st_q.hw_trim_enable && !ev_eval |=> $stable(trim_code_o))
      else $error("trim code changed without evaluation in auto mode");

   soft_pulse_a: assert property (trim_wr_s ##0 (pstrb_i[0] && pwdata_i[OTC_SOFT_PULSE_BIT])
      |=> st_q.soft_sync_pulse ##1 !st_q.soft_sync_pulse)
      else $error("soft sync pulse not single");

   ref_lock_a: assert property (st_q.trim_counter_enable |=> $stable(st_q.ref_config))
      else $error("reference config changed while counting");

   irq_gate_a: assert property (irq_o == |(st_q.flags & st_q.irq_enable))
      else $error("interrupt disagrees with enabled flags");

   step_one_a: assert property (auto_step_s(1'b1, 2'h1) ##0 (trim_code_o < OTC_TRIM_MAX)
      |=> trim_code_o == $past(trim_code_o) + 6'h01)
      else $error("single step raise wrong");

   step_two_dn_a: assert property (auto_step_s(1'b0, 2'h2) ##0 (trim_code_o > 6'h01)
      |=> trim_code_o == $past(trim_code_o) - 6'h02)
      else $error("double step lower wrong");

   trim_sat_a: assert property (auto_step_s(1'b1, 2'h2) ##0 (trim_code_o > 6'h3d)
      |=> trim_code_o == OTC_TRIM_MAX && st_q.trim_range_error)
      else $error("trim overflow not saturated");

   trim_floor_a: assert property (auto_step_s(1'b0, 2'h2) ##0 (trim_code_o < 6'h02)
      |=> trim_code_o == OTC_TRIM_MIN && st_q.trim_range_error)
      else $error("trim underflow not saturated");

   hw_enable_wr_a: assert property (trim_wr_s ##0 pstrb_i[0]
      |=> st_q.hw_trim_enable == $past(pwdata_i[OTC_HW_TRIM_BIT]))
      else $error("auto trim enable write lost");

   cnt_enable_wr_a: assert property (trim_wr_s ##0 pstrb_i[0]
      |=> st_q.trim_counter_enable == $past(pwdata_i[OTC_CNT_EN_BIT]))
      else $error("counter enable write lost");

   auto_keep_a: assert property (st_q.hw_trim_enable && ev_eval && ev_step == 2'h0
      |=> $stable(trim_code_o))
      else $error("trim code moved on in-range evaluation");

   ok_flag_a: assert property (ev_eval && ev_ok |=> st_q.flags[OTC_IRQ_OK])
      else $error("ok flag not set");

   warn_flag_a: assert property (ev_eval && ev_warn |=> st_q.flags[OTC_IRQ_WARN])
      else $error("warning flag not set");

   slow_flag_a: assert property (ev_eval && ev_slow
      |=> st_q.trim_too_slow_error && st_q.flags[OTC_IRQ_ERR])
      else $error("too slow error not set");

   miss_flag_a: assert property (ev_miss |=> st_q.ref_pulse_missing && st_q.flags[OTC_IRQ_ERR])
      else $error("missing pulse error not set");

   eref_flag_a: assert property (ev_zero |=> st_q.flags[OTC_IRQ_EREF])
      else $error("expected reference flag not set");
endmodule : otc_top
`default_nettype wire

// ===== sim/otc_ref_model.sv
// Reference pulse source driving one of the three reference lines
`default_nettype none
module otc_ref_model (
   input  wire logic        mclk_i,
   input  wire logic [1:0]  line_i,
   input  wire logic [15:0] period_i,
   output logic      [2:0]  ref_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_q = 16'h0000;
   // Held 4 clocks so the synchroniser sees each level
   always @(posedge mclk_i) begin
      cnt_q <= (period_i == 16'h0 || cnt_q >= period_i - 16'h1) ? 16'h0 : cnt_q + 16'h1;
      ref_o <= (period_i != 16'h0 && cnt_q < 16'h4) ? 3'b001 << line_i : 3'b000;
   end
endmodule : otc_ref_model
`default_nettype wire

// ===== sim/testbench.sv
// Register-level testbench of the oscillator trim control block
`default_nettype none
module testbench
   import otc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hf;
   logic [3:0]  strb_v = 4'hf;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic [5:0]  trim;
   logic [2:0]  ref_l;
   logic [1:0]  line = 2'h0;
   logic [15:0] period = 16'h0;
   logic [31:0] rdv;
   logic        erv;
   int          error_cnt = 0;
   int          checks_done = 0;
   otc_top dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
      .ref_gpio_i(ref_l[0]), .ref_low_speed_crystal_i(ref_l[1]), .ref_sof_i(ref_l[2]), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .trim_code_o(trim));
   otc_ref_model ref_u (.mclk_i(mclk_i), .line_i(line), .period_i(period), .ref_o(ref_l));
   always #12.5 mclk_i = ~mclk_i;
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= strb_v;
      @(posedge mclk_i);
      penable <= 1'b1;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk("pready", 32'h1, 32'h0);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk("read data", exp, rdv);
   endtask : rd
   task automatic spulse(input int gap, input logic [5:0] et, input logic ei);
      apb(1'b1, OTC_OFF_TRIM_CTL, 32'h0000_20e2);
      repeat (gap) @(posedge mclk_i);
      chk("trim", {26'h0, et}, {26'h0, trim});
      chk("irq", {31'h0, ei}, {31'h0, irq});
   endtask : spulse
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   initial begin
      #1ms;
      error_cnt++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      rd(OTC_OFF_TRIM_CTL, OTC_TRIM_CTL_RST);
      rd(OTC_OFF_REF_CFG, OTC_REF_CFG_RST);
      chk("trim", 32'h20, {26'h0, trim});
      apb(1'b1, OTC_OFF_TRIM_CTL, 32'h0000_1580);
      rd(OTC_OFF_TRIM_CTL, 32'h0000_1500);
      chk("trim", 32'h15, {26'h0, trim});
      apb(1'b1, OTC_OFF_TRIM_CTL, 32'h0000_1540);
      apb(1'b1, OTC_OFF_TRIM_CTL, 32'h0000_3f40);
      rd(OTC_OFF_TRIM_CTL, 32'h0000_1540);
      apb(1'b1, OTC_OFF_REF_CFG, 32'hffff_ffff);
      rd(OTC_OFF_REF_CFG, OTC_REF_CFG_MASK);
      apb(1'b1, OTC_OFF_REF_CFG, 32'h0008_00c8);
      strb_v = 4'h3;
      apb(1'b1, OTC_OFF_REF_CFG, 32'h1234_5678);
      strb_v = 4'hf;
      rd(OTC_OFF_REF_CFG, 32'h0008_00c8);
      rd(8'h10, 32'h0);
      chk("slave error", 32'h1, {31'h0, erv});
      apb(1'b1, OTC_OFF_TRIM_CTL, 32'h0000_2000);
      apb(1'b1, OTC_OFF_TRIM_CTL, 32'h0000_2060);
      apb(1'b1, OTC_OFF_REF_CFG, 32'h3000_0001);
      rd(OTC_OFF_REF_CFG, 32'h0008_00c8);
      spulse(182, 6'h20, 1'b0);
      spulse(148, 6'h21, 1'b0);
      spulse(195, 6'h23, 1'b1);
      spulse(248, 6'h23, 1'b1);
      spulse(20, 6'h21, 1'b1);
      apb(1'b0, OTC_OFF_STATUS, 32'h0);
      chk("ok warn", 32'h3, rdv & 32'h3);
      chk("status", 32'h0031_000b, rdv);
      apb(1'b1, OTC_OFF_FLAG_CLR, 32'h0000_070f);
      // Clear and irq both land at the last edge of apb, seen from this edge on
      @(posedge mclk_i);
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'b1, OTC_OFF_TRIM_CTL, 32'h0000_2040);
      apb(1'b1, OTC_OFF_REF_CFG, 32'h1108_00c8);
      line <= 2'h1;
      period <= 16'd75;
      apb(1'b1, OTC_OFF_TRIM_CTL, 32'h0000_2064);
      repeat (6000) @(posedge mclk_i);
      chk("trim", 32'h3f, {26'h0, trim});
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b0, OTC_OFF_STATUS, 32'h0);
      chk("range error", 32'h400, rdv & 32'h400);
      chk("capture", 32'h0033_8000, rdv & 32'hffff_8000);
      apb(1'b1, OTC_OFF_TRIM_CTL, 32'h0000_2040);
      apb(1'b1, OTC_OFF_REF_CFG, 32'ha008_00c8);
      line <= 2'h2;
      period <= 16'd250;
      apb(1'b1, OTC_OFF_TRIM_CTL, 32'h0000_2060);
      repeat (10000) @(posedge mclk_i);
      chk("trim", 32'h0, {26'h0, trim});
      stop_test();
   end
endmodule : testbench
`default_nettype wire
